// [core/sebf_defines.svh]
`ifndef SEBF_DEFINES_SVH
`define SEBF_DEFINES_SVH

// -----------------------------------------------------------------
// Address word layout
// -----------------------------------------------------------------
`define SEBF_ID_PATTERN   5'h14
`define SEBF_ID_MSB       7
`define SEBF_ID_LSB       3
`define SEBF_SEL_POS      2
`define SEBF_PAGE_POS     1
`define SEBF_DIR_POS      0
`define SEBF_WORD_BITS    4'h8

// -----------------------------------------------------------------
// Timing and sizes
// -----------------------------------------------------------------
`define SEBF_CLK_MHZ      20
`define SEBF_PROG_TIME_MS 10
`define SEBF_PROG_CYCLES  (`SEBF_PROG_TIME_MS * 1000 * `SEBF_CLK_MHZ)
`define SEBF_FIFO_WIDTH   8
`define SEBF_FIFO_DEPTH   4
`define SEBF_SYNC_INPUTS  4

`endif

// [core/sebf_pkg.sv]
`default_nettype none
package sebf_pkg;

  // One-hot states of the front end
  typedef enum logic [6:0] {
    ST_STBY = 7'h01,
    ST_ADDR = 7'h02,
    ST_AACK = 7'h04,
    ST_WRX  = 7'h08,
    ST_WACK = 7'h10,
    ST_READ = 7'h20,
    ST_PROG = 7'h40
  } sebf_state_t;

endpackage : sebf_pkg
`default_nettype wire

// [core/sebf_fifo.sv]
`include "sebf_defines.svh"
`default_nettype none
module sebf_fifo #(
  parameter int WIDTH = `SEBF_FIFO_WIDTH,
  parameter int DEPTH = `SEBF_FIFO_DEPTH
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  logic             out_valid_r;
  logic [WIDTH-1:0] out_data_r;
  wire              push;
  wire              pop;
  wire  [AW:0]      wr_ptr_nxt;
  wire  [AW:0]      rd_ptr_nxt;
  wire              bypass;

  // -----------------------------------------------------------------
  // Flags: extra pointer bit tells full from empty
  // -----------------------------------------------------------------
  assign in_ready_o  = !((wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                         (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]));
  assign out_valid_o = out_valid_r;
  assign out_data_o  = out_data_r;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_r && out_ready_i;
  assign wr_ptr_nxt  = wr_ptr_r + (AW+1)'(push);
  assign rd_ptr_nxt  = rd_ptr_r + (AW+1)'(pop);
  // Head register keeps the storage mux off the port; a word landing in
  // the slot that is about to become the head has to bypass the storage
  assign bypass      = push && (wr_ptr_r[AW-1:0] == rd_ptr_nxt[AW-1:0]);

  // Storage has no reset; only the pointers decide what is valid
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
    end
  end

  // Pointer and head register update
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_r    <= '0;
      rd_ptr_r    <= '0;
      out_valid_r <= 1'b0;
      out_data_r  <= '0;
    end else begin
      wr_ptr_r    <= wr_ptr_nxt;
      rd_ptr_r    <= rd_ptr_nxt;
      out_valid_r <= (wr_ptr_nxt != rd_ptr_nxt);
      out_data_r  <= bypass ? in_data_i : mem_r[rd_ptr_nxt[AW-1:0]];
    end
  end
endmodule : sebf_fifo
`default_nettype wire

// [core/sebf_front_end.sv]
`include "sebf_defines.svh"
`default_nettype none
module sebf_front_end
  import sebf_pkg::*;
#(
  parameter int PROG_CYCLES = `SEBF_PROG_CYCLES
) (
  input  wire logic                        core_clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        scl_i,
  input  wire logic                        sda_i,
  output logic                             sda_o,
  output logic                             sda_oe_n_o,
  input  wire logic                        device_select_strap_i,
  input  wire logic                        write_protect_i,
  output logic [`SEBF_FIFO_WIDTH-1:0]      wr_data_o,
  output logic                             wr_valid_o,
  input  wire logic                        wr_ready_i,
  output logic                             page_address_bit_o,
  output logic                             read_mode_o,
  output logic                             standby_o,
  output logic                             prog_busy_o,
  output logic                             prog_start_o
);

  // -----------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------
  // Order: scl, sda, strap, write protect
  wire  [`SEBF_SYNC_INPUTS-1:0] pin_raw;
  logic [`SEBF_SYNC_INPUTS-1:0] sync1_r;
  logic [`SEBF_SYNC_INPUTS-1:0] sync2_r;

  assign pin_raw = {write_protect_i, device_select_strap_i, sda_i, scl_i};

  genvar gi;
  generate
    for (gi = 0; gi < `SEBF_SYNC_INPUTS; gi++) begin : g_sync
      // Two stages; only the second stage is read by logic
      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          sync1_r[gi] <= 1'b1;
          sync2_r[gi] <= 1'b1;
        end else begin
          sync1_r[gi] <= pin_raw[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  wire scl_s   = sync2_r[0];
  wire sda_s   = sync2_r[1];
  wire strap_s = sync2_r[2];
  wire wp_s    = sync2_r[3];

  // -----------------------------------------------------------------
  // Bus event detection
  // -----------------------------------------------------------------
  logic scl_d_r;
  logic sda_d_r;

  // Previous samples for edge finding
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  wire scl_rise = scl_s && !scl_d_r;
  wire scl_fall = !scl_s && scl_d_r;
  wire scl_high = scl_s && scl_d_r;
  wire start_ev = scl_high && sda_d_r && !sda_s;
  wire stop_ev  = scl_high && !sda_d_r && sda_s;

  // -----------------------------------------------------------------
  // Word shifter and address decode
  // -----------------------------------------------------------------
  sebf_state_t                 state_r;
  sebf_state_t                 state_nxt;
  logic [3:0]                  bit_cnt_r;
  logic [7:0]                  shift_r;
  logic                        sda_oe_n_r;
  logic                        sda_out_r;
  logic                        wrote_any_r;
  logic                        page_r;
  logic                        read_r;
  logic                        standby_r;
  logic                        prog_busy_r;
  logic                        prog_start_r;
  logic [$clog2(PROG_CYCLES+1)-1:0] prog_cnt_r;

  function automatic logic addr_match(input logic [7:0] w, input logic sel);
    addr_match = (w[`SEBF_ID_MSB:`SEBF_ID_LSB] == `SEBF_ID_PATTERN) &&
                 (w[`SEBF_SEL_POS] == sel);
  endfunction : addr_match

  // word complete after eighth clock falls
  wire word_end  = scl_fall && (bit_cnt_r == `SEBF_WORD_BITS);
  // strap floats low outside, so sampled level is used as is
  wire match     = addr_match(shift_r, strap_s);
  wire in_prog   = (state_r == ST_PROG);
  wire in_wr     = (state_r == ST_WRX) || (state_r == ST_WACK);
  wire prog_done = in_prog && (prog_cnt_r == '0);
  wire fifo_ready;
  // protected words are dropped, never pushed
  wire push      = word_end && (state_r == ST_WRX) && !wp_s && fifo_ready;
  // A full queue refuses the word by withholding the acknowledge
  wire data_ack  = word_end && (state_r == ST_WRX) && (wp_s || fifo_ready);

  // Shift register and bit count; sample only on rising clock
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_cnt_r <= 4'h0;
      shift_r   <= 8'h00;
    end else if (start_ev || state_nxt != state_r) begin
      bit_cnt_r <= 4'h0;
    end else if (scl_rise && bit_cnt_r != `SEBF_WORD_BITS) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      shift_r   <= {shift_r[6:0], sda_s};
    end
  end

  // -----------------------------------------------------------------
  // State machine
  // -----------------------------------------------------------------
  // Next state; outside programming, stop and start override bit handling
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_STBY: begin
        state_nxt = ST_STBY;
      end
      ST_ADDR: begin
        // mismatch goes quiet until the next start
        if (word_end) begin
          state_nxt = match ? ST_AACK : ST_STBY;
        end
      end
      ST_AACK: begin
        if (scl_fall) begin
          state_nxt = read_r ? ST_READ : ST_WRX;
        end
      end
      ST_WRX: begin
        if (word_end) begin
          state_nxt = data_ack ? ST_WACK : ST_STBY;
        end
      end
      ST_WACK: begin
        if (scl_fall) begin
          state_nxt = ST_WRX;
        end
      end
      ST_READ: begin
        state_nxt = ST_READ;
      end
      ST_PROG: begin
        if (prog_done) begin
          state_nxt = ST_STBY;
        end
      end
    endcase
    if (!in_prog) begin
      if (start_ev) begin
        state_nxt = ST_ADDR;
      end else if (stop_ev) begin
        // stop after read or idle returns to standby
        state_nxt = (in_wr && wrote_any_r) ? ST_PROG : ST_STBY;
      end
    end
  end

  // standby after reset, the power-up stand-in
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_STBY;
    end else begin
      state_r <= state_nxt;
    end
  end

  // -----------------------------------------------------------------
  // Address capture and write bookkeeping
  // -----------------------------------------------------------------
  // page bit kept as the top word address bit
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      page_r      <= 1'b0;
      read_r      <= 1'b0;
      wrote_any_r <= 1'b0;
    end else begin
      if (word_end && state_r == ST_ADDR && match) begin
        page_r <= shift_r[`SEBF_PAGE_POS];
        read_r <= shift_r[`SEBF_DIR_POS];
      end
      if (start_ev && !in_prog) begin
        wrote_any_r <= 1'b0;
      end else if (push) begin
        wrote_any_r <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // Acknowledge driver
  // -----------------------------------------------------------------
  wire ack_on  = (word_end && state_r == ST_ADDR && match) || data_ack;
  wire ack_off = scl_fall && (state_r == ST_AACK || state_r == ST_WACK);

  // pull data low through the ninth clock
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_oe_n_r <= 1'b1;
      sda_out_r  <= 1'b0;
    end else if (ack_on && !start_ev && !stop_ev) begin
      sda_oe_n_r <= 1'b0;
    end else if (ack_off || start_ev || stop_ev) begin
      sda_oe_n_r <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // Internal programming timer
  // -----------------------------------------------------------------
  // load full time on entry, count down to zero
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prog_cnt_r <= '0;
    end else if (state_nxt == ST_PROG && !in_prog) begin
      prog_cnt_r <= ($bits(prog_cnt_r))'(PROG_CYCLES - 1);
    end else if (in_prog && prog_cnt_r != '0) begin
      prog_cnt_r <= prog_cnt_r - 1'b1;
    end
  end

  // Status flags from registered next state
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      standby_r    <= 1'b1;
      prog_busy_r  <= 1'b0;
      prog_start_r <= 1'b0;
    end else begin
      standby_r    <= (state_nxt == ST_STBY);
      prog_busy_r  <= (state_nxt == ST_PROG);
      prog_start_r <= (state_nxt == ST_PROG) && !in_prog;
    end
  end

  // -----------------------------------------------------------------
  // Write data queue
  // -----------------------------------------------------------------
  sebf_fifo #(
    .WIDTH (`SEBF_FIFO_WIDTH),
    .DEPTH (`SEBF_FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_ready),
    .in_data_i   (shift_r),
    .out_valid_o (wr_valid_o),
    .out_ready_i (wr_ready_i),
    .out_data_o  (wr_data_o)
  );

  assign sda_o              = sda_out_r;
  assign sda_oe_n_o         = sda_oe_n_r;
  assign page_address_bit_o = page_r;
  assign read_mode_o        = read_r;
  assign standby_o          = standby_r;
  assign prog_busy_o        = prog_busy_r;
  assign prog_start_o       = prog_start_r;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_addr_end;
    word_end && state_r == ST_ADDR;
  endsequence

  sequence s_ack_window;
    !sda_oe_n_r [*1] ##0 (state_r == ST_AACK);
  endsequence

  a_start_addr: assert property (start_ev && !in_prog |=> state_r == ST_ADDR)
    else $error("start did not open an address word");
  a_stop_standby: assert property (stop_ev && state_r == ST_READ |=> standby_o)
    else $error("stop after read did not enter standby");
  a_addr_ack: assert property (s_addr_end and match |=> s_ack_window)
    else $error("matching address not acknowledged");
  a_miss_quiet: assert property (s_addr_end and !match |=> state_r == ST_STBY && sda_oe_n_r)
    else $error("mismatched address answered");
  a_page_capture: assert property (s_addr_end and match |=> page_r == $past(shift_r[1]))
    else $error("page bit not captured");
  a_dir_capture: assert property (s_addr_end and match |=> read_r == $past(shift_r[0]))
    else $error("direction bit not captured");
  a_wp_block: assert property (word_end && state_r == ST_WRX && wp_s |=> $stable(wrote_any_r))
    else $error("write pushed while protected");
  a_prog_entry: assert property (stop_ev && in_wr && wrote_any_r |=> in_prog ##1 prog_busy_o)
    else $error("write stop did not start programming");
  a_prog_bound: assert property (in_prog |-> prog_cnt_r < ($bits(prog_cnt_r))'(PROG_CYCLES))
    else $error("programming counter out of range");
  a_prog_quiet: assert property (in_prog |-> sda_oe_n_r && !push)
    else $error("bus answered during programming");
  a_reset_stby: assert property ($rose(rst_n_i) |-> standby_o)
    else $error("not in standby after reset");

endmodule : sebf_front_end
`default_nettype wire

// [bench/sebf_bus_ctrl.sv]
`default_nettype none
module sebf_bus_ctrl (
  input  wire logic core_clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_drv_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------
  // Two-wire controller model
  // --------------------------------
  // Half period of the 400 ns link clock in core cycles
  localparam int HALF = 4;

  // Idle bus: clock stands high, data released to the pull-up
  initial begin
    scl_o     = 1'b1;
    sda_drv_o = 1'b1;
  end

  task automatic wait_half();
    repeat (HALF) @(posedge core_clk_i);
  endtask : wait_half

  // data moves only while the clock is low
  // One spare cycle after the fall gives the data hold time
  task automatic bit_out(input logic b, output logic s);
    @(posedge core_clk_i);
    sda_drv_o <= b;
    repeat (HALF - 1) @(posedge core_clk_i);
    scl_o <= 1'b1;
    repeat (HALF / 2) @(posedge core_clk_i);
    s = sda_i;
    repeat (HALF / 2) @(posedge core_clk_i);
    scl_o <= 1'b0;
  endtask : bit_out

  // start, with a stretched low phase so the device can let go of an acknowledge
  task automatic start_cond();
    wait_half();
    sda_drv_o <= 1'b1;
    wait_half();
    scl_o <= 1'b1;
    wait_half();
    sda_drv_o <= 1'b0;
    wait_half();
    scl_o <= 1'b0;
  endtask : start_cond

  // stop, then idle long enough for standby to show
  task automatic stop_cond();
    wait_half();
    sda_drv_o <= 1'b0;
    wait_half();
    scl_o <= 1'b1;
    wait_half();
    sda_drv_o <= 1'b1;
    repeat (3) wait_half();
  endtask : stop_cond

  // eight bits, MSB first, released in the ninth for the acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_out(b[i], s);
    end
    bit_out(1'b1, s);
    ack = ~s;
  endtask : send_byte

  // up to nine clocks until data is seen high, a start follows
  task automatic recover();
    logic s;
    for (int i = 0; i < 9; i++) begin
      bit_out(1'b1, s);
      if (s === 1'b1) begin
        break;
      end
    end
  endtask : recover
endmodule : sebf_bus_ctrl
`default_nettype wire

// [bench/tb_serial_eeprom_bus_front_end.sv]
`include "sebf_defines.svh"
`default_nettype none
module tb_serial_eeprom_bus_front_end
  import sebf_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------
  // Bench wiring
  // --------------------------------
  // Shortened programming time keeps the run brief
  localparam int PROG = 400;
  logic       clk, rst_n, strap, wp, wr_ready;
  wire logic  scl, sda_drv, sda, sda_o, sda_oe_n;
  wire logic  wr_valid, page, rmode, stby, busy, pstart;
  logic [7:0] wr_data;
  int         n_fail, total_checks, seed, cyc, n_pstart;
  logic [7:0] q[$];

  // Open-drain wire with pull-up: low if either party pulls
  assign sda = sda_drv & (sda_oe_n | sda_o);

  sebf_bus_ctrl sebf_bus_ctrl_i (.core_clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_drv_o(sda_drv));

  sebf_front_end #(.PROG_CYCLES(PROG)) sebf_front_end_i (
    .core_clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n), .device_select_strap_i(strap), .write_protect_i(wp),
    .wr_data_o(wr_data), .wr_valid_o(wr_valid), .wr_ready_i(wr_ready),
    .page_address_bit_o(page), .read_mode_o(rmode), .standby_o(stby),
    .prog_busy_o(busy), .prog_start_o(pstart));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) cyc <= cyc + 1;

  // Programming start stands one cycle only, so it is counted at every edge
  always @(posedge clk) begin
    if (pstart === 1'b1) begin
      n_pstart <= n_pstart + 1;
    end
  end

  // --------------------------------
  // Checking helpers
  // --------------------------------
  task automatic cmp_flag(input string w, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %b seen %b", w, e, g);
    end
  endtask : cmp_flag

  task automatic cmp_word(input string w, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask : cmp_word

  task automatic finish_test();
    if (n_fail == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  // Model: words accepted with protection off join the queue
  task automatic wr_frame(input int n, input int acked);
    logic       ack;
    logic [7:0] d;
    sebf_bus_ctrl_i.start_cond();
    sebf_bus_ctrl_i.send_byte({`SEBF_ID_PATTERN, strap, 2'b00}, ack);
    cmp_flag("wr_addr_ack", 1'b1, ack);
    cmp_flag("wr_mode", 1'b0, rmode);
    cmp_flag("wr_page", 1'b0, page);
    for (int k = 0; k < n; k++) begin
      d = 8'($random(seed));
      sebf_bus_ctrl_i.send_byte(d, ack);
      cmp_flag("data_ack", k < acked, ack);
      if (k < acked && wp === 1'b0) q.push_back(d);
    end
  endtask : wr_frame

  task automatic poll(input logic e);
    logic ack;
    sebf_bus_ctrl_i.start_cond();
    sebf_bus_ctrl_i.send_byte({`SEBF_ID_PATTERN, strap, 2'b00}, ack);
    cmp_flag("poll_ack", e, ack);
    sebf_bus_ctrl_i.stop_cond();
  endtask : poll

  // Consumer stalls during frames, then takes one word at a time
  task automatic drain();
    int t;
    while (q.size() > 0) begin
      t = 0;
      while (wr_valid !== 1'b1 && t < 50) begin
        @(posedge clk);
        t++;
      end
      cmp_flag("wr_valid", 1'b1, wr_valid);
      cmp_word("wr_data", q.pop_front(), wr_data);
      wr_ready <= 1'b1;
      @(posedge clk);
      wr_ready <= 1'b0;
      @(posedge clk);
    end
    cmp_flag("queue_empty", 1'b0, wr_valid);
  endtask : drain

  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    logic [7:0] a;
    logic       ack, e, pg;
    int         t, t0;
    seed = 74088;
    n_fail = 0;
    total_checks = 0;
    cyc = 0;
    n_pstart = 0;
    rst_n = 1'b0;
    strap = 1'b0;
    wp = 1'b0;
    wr_ready = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    cmp_flag("standby", 1'b1, stby);
    cmp_flag("ack_off", 1'b1, sda_oe_n);
    repeat (3) @(posedge clk);
    sebf_bus_ctrl_i.recover();
    // Address decode: strap, select, page, corrupted pattern
    for (int i = 0; i < 8; i++) begin
      strap <= i[1];
      pg = 1'($random(seed));
      a = {(i >= 6) ? (`SEBF_ID_PATTERN ^ (5'h01 << i[0])) : `SEBF_ID_PATTERN, i[0], pg, 1'b1};
      e = (a[7:3] === `SEBF_ID_PATTERN) && (a[2] === i[1]);
      @(posedge clk);
      sebf_bus_ctrl_i.start_cond();
      sebf_bus_ctrl_i.send_byte(a, ack);
      cmp_flag("addr_ack", e, ack);
      if (e) begin
        cmp_flag("read_mode", 1'b1, rmode);
        cmp_flag("page_bit", pg, page);
      end
      sebf_bus_ctrl_i.stop_cond();
      cmp_flag("standby", 1'b1, stby);
    end
    // Four words, stop, programming with polling
    wr_frame(4, 4);
    sebf_bus_ctrl_i.stop_cond();
    t0 = cyc;
    cmp_flag("prog_busy", 1'b1, busy);
    poll(1'b0);
    t = 0;
    while (busy === 1'b1 && t < PROG + 50) begin
      @(posedge clk);
      t++;
    end
    cmp_flag("prog_time", 1'b1, (cyc - t0 <= PROG + 40) && (cyc - t0 >= PROG - 40));
    cmp_flag("standby", 1'b1, stby);
    poll(1'b1);
    cmp_flag("no_prog", 1'b0, busy);
    drain();
    // Full queue refuses the fifth word; repeated start cancels
    wr_frame(5, 4);
    sebf_bus_ctrl_i.start_cond();
    sebf_bus_ctrl_i.send_byte({`SEBF_ID_PATTERN, strap, 2'b01}, ack);
    cmp_flag("rd_addr_ack", 1'b1, ack);
    sebf_bus_ctrl_i.stop_cond();
    cmp_flag("cancelled", 1'b0, busy);
    drain();
    // Protected writes are dropped and never programmed
    wp <= 1'b1;
    wr_frame(2, 2);
    sebf_bus_ctrl_i.stop_cond();
    cmp_flag("wp_busy", 1'b0, busy);
    cmp_flag("wp_queue", 1'b0, wr_valid);
    wp <= 1'b0;
    // Only the first write frame may have started a programming cycle
    cmp_flag("prog_starts", 1'b1, n_pstart == 1);
    finish_test();
  end

  // Watchdog well beyond the few thousand cycles the sequence needs
  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    finish_test();
  end
endmodule : tb_serial_eeprom_bus_front_end
`default_nettype wire
